// file: logic/slo_strap_top.sv
`timescale 1ns/1ns
module slo_strap_top
   import slo_pkg::*;
(
   // clocks and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic hard_rst_n_in,
   // straps
   input wire logic rx_lane_reverse_strap_in,
   input wire logic tx_lane_reverse_strap_in,
   // per-port single-lane selection and interrupt request
   input wire logic [SLO_PORTS-1:0] narrow_mode_in,
   input wire logic irq_req_in,
   // lane selects, flattened two bits per lane, four lanes per port
   output logic [SLO_PORTS*8-1:0] rx_lane_sel_out,
   output logic [SLO_PORTS*8-1:0] tx_lane_sel_out,
   // captured straps and status
   output logic rx_reverse_out,
   output logic tx_reverse_out,
   output logic straps_locked_out,
   output logic [SLO_PORTS-1:0] wide_only_out,
   // open-drain interrupt: output low, enable high while pulling
   output logic int_n_out,
   output logic int_n_oe_out
);
   // hard reset pin is asynchronous; sync it before use
   logic hr_s1, hr_s2, hard_rst;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         hr_s1 <= 1'h0;
         hr_s2 <= 1'h0;
      end else begin
         hr_s1 <= hard_rst_n_in;
         hr_s2 <= hr_s1;
      end
   end
   assign hard_rst = srst_in || !hr_s2;

   // strap pins pass two flops before use
   logic rx_s1, rx_s2, tx_s1, tx_s2;
   always_ff @(posedge ref_clk_in) begin
      rx_s1 <= rx_lane_reverse_strap_in;
      rx_s2 <= rx_s1;
      tx_s1 <= tx_lane_reverse_strap_in;
      tx_s2 <= tx_s1;
   end

   // sampling window: count hold cycles after release, then lock
   slo_state_t state;
   logic [3:0] cnt;
   always_ff @(posedge ref_clk_in) begin
      if (hard_rst) begin
         state <= SLO_IN_RESET;
         cnt <= SLO_CNT_RST;
      end else begin
         unique case (state)
            SLO_IN_RESET: begin
               state <= SLO_SAMPLING;
            end
            SLO_SAMPLING: begin
               // board keeps straps steady this long, we sample at the end
               if (cnt == 4'(SLO_STRAP_HOLD_CYC - 1)) begin
                  state <= SLO_LOCKED;
               end
               cnt <= cnt + 4'h1;
            end
            SLO_LOCKED: begin
               state <= SLO_LOCKED;
            end
            default: begin
               state <= SLO_IN_RESET;
            end
         endcase
      end
   end

   // capture straps only while sampling; held after lock
   // the strap syncs lag two cycles, so the last window cycle would read a pin
   // level from past its hold time; that cycle is skipped
   logic rx_rev, tx_rev;
   always_ff @(posedge ref_clk_in) begin
      if (hard_rst) begin
         rx_rev <= SLO_STRAP_RST;
         tx_rev <= SLO_STRAP_RST;
      end else if (state == SLO_SAMPLING && cnt != 4'(SLO_STRAP_HOLD_CYC - 1)) begin
         rx_rev <= rx_s2;
         tx_rev <= tx_s2;
      end
   end

   // lane mapping per port and direction; only ports 0 and 6 reverse
   logic [SLO_PORTS*8-1:0] next_rx_sel, next_tx_sel;
   logic [SLO_PORTS-1:0] next_wide_only;
   genvar p;
   generate
      for (p = 0; p < SLO_PORTS; p++) begin : g_port
         localparam bit REV_OK = (p == SLO_REV_PORT_A) || (p == SLO_REV_PORT_B);
         slo_lane_if rx_if ();
         slo_lane_if tx_if ();
         assign rx_if.reverse = REV_OK && rx_rev;
         assign rx_if.narrow = narrow_mode_in[p];
         assign tx_if.reverse = REV_OK && tx_rev;
         assign tx_if.narrow = 1'h0;
         slo_lane_map u_rx (.lif(rx_if));
         slo_lane_map u_tx (.lif(tx_if));
         assign next_rx_sel[p*8 +: 8] =
            {rx_if.sel[3], rx_if.sel[2], rx_if.sel[1], rx_if.sel[0]};
         assign next_tx_sel[p*8 +: 8] =
            {tx_if.sel[3], tx_if.sel[2], tx_if.sel[1], tx_if.sel[0]};
         // a reversed port cannot link in single-lane mode
         assign next_wide_only[p] = rx_if.reverse || tx_if.reverse;
      end
   endgenerate

   // registered outputs; the one clock also stands for the serial reference
   always_ff @(posedge ref_clk_in) begin
      if (hard_rst) begin
         rx_lane_sel_out <= '0;
         tx_lane_sel_out <= '0;
         rx_reverse_out <= 1'h0;
         tx_reverse_out <= 1'h0;
         straps_locked_out <= 1'h0;
         wide_only_out <= '0;
      end else begin
         rx_lane_sel_out <= next_rx_sel;
         tx_lane_sel_out <= next_tx_sel;
         rx_reverse_out <= rx_rev;
         tx_reverse_out <= tx_rev;
         straps_locked_out <= (state == SLO_LOCKED);
         wide_only_out <= next_wide_only;
      end
   end

   // open drain: pull low when interrupt pending, else release
   always_ff @(posedge ref_clk_in) begin
      if (hard_rst) begin
         int_n_out <= 1'h0;
         int_n_oe_out <= 1'h0;
      end else begin
         int_n_out <= 1'h0;
         int_n_oe_out <= irq_req_in;
      end
   end

   // straps frozen once locked
   locked_hold_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      state == SLO_LOCKED |=> $stable(rx_rev) && $stable(tx_rev))
      else $error("strap changed after lock");
   // lock takes eleven cycles after release: one in reset state, ten sampling
   sequence slo_window_s;
      state == SLO_SAMPLING ##10 state == SLO_LOCKED;
   endsequence
   lock_time_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      state == SLO_IN_RESET |=> slo_window_s)
      else $error("lock timing wrong");
   // non-reversible port stays natural once the outputs leave reset
   natural_port_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      !$past(hard_rst) |-> rx_lane_sel_out[15:8] == 8'he4)
      else $error("port 1 reordered");
   // port 0 rx order follows strap
   rx_order_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      ##1 !$past(hard_rst) |-> rx_lane_sel_out[7:0] ==
      (($past(rx_rev) && !$past(narrow_mode_in[0])) ? 8'h1b : 8'he4))
      else $error("rx order wrong");
   // port 6 tx order follows strap
   tx_order_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      ##1 !$past(hard_rst) |-> tx_lane_sel_out[55:48] == ($past(tx_rev) ? 8'h1b : 8'he4))
      else $error("tx order wrong");
   // single-lane mode ignores rx reversal
   narrow_ign_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      narrow_mode_in[6] |=> rx_lane_sel_out[55:48] == 8'he4)
      else $error("narrow port reversed");
   // wide-only flag follows reversal
   wide_flag_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      rx_rev |=> wide_only_out[0] && !wide_only_out[1])
      else $error("wide-only flag wrong");
   // interrupt pin pulls only on request
   irq_pull_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      irq_req_in |=> int_n_oe_out && !int_n_out)
      else $error("interrupt not pulled");
   // hard reset clears captured straps
   reset_clr_a: assert property (@(posedge ref_clk_in)
      !hr_s2 |=> !rx_rev && !tx_rev)
      else $error("reset did not clear");
   // no capture outside the window
   outside_win_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      state != SLO_SAMPLING |=> $stable(rx_rev) && $stable(tx_rev))
      else $error("strap captured outside window");
   // last window cycle would read a strap past its hold time, so it is skipped
   late_skip_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      state == SLO_SAMPLING && cnt == 4'(SLO_STRAP_HOLD_CYC - 1)
      |=> $stable(rx_rev) && $stable(tx_rev))
      else $error("strap captured past hold time");
   // lock flag follows the window state
   lock_flag_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      state == SLO_LOCKED |=> straps_locked_out)
      else $error("lock flag missing");
   // captured straps shown one cycle later
   rev_out_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      ##1 !$past(hard_rst) |-> rx_reverse_out == $past(rx_rev)
      && tx_reverse_out == $past(tx_rev))
      else $error("captured strap not shown");
   // transmit lanes of a fixed port stay natural
   tx_natural_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      !$past(hard_rst) |-> tx_lane_sel_out[63:56] == 8'he4)
      else $error("port 7 reordered");
   // transmit reversal also marks port 6 wide-only
   tx_wide_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      tx_rev |=> wide_only_out[6] && !wide_only_out[7])
      else $error("tx wide-only flag wrong");
   // outputs cleared while reset holds
   reset_out_a: assert property (@(posedge ref_clk_in)
      hard_rst |=> !straps_locked_out && rx_lane_sel_out == '0 && wide_only_out == '0)
      else $error("outputs not cleared");
   // pin released when nothing is pending
   irq_free_a: assert property (@(posedge ref_clk_in) disable iff (hard_rst)
      !irq_req_in |=> !int_n_oe_out)
      else $error("interrupt pin not released");
endmodule // slo_strap_top

// file: pkg/slo_pkg.sv
package slo_pkg;
   // lanes per wide port and number of serial ports handled here
   localparam int SLO_LANES = 4;
   localparam int SLO_PORTS = 8;
   // ports that may have their lanes reversed
   localparam int SLO_REV_PORT_A = 0;
   localparam int SLO_REV_PORT_B = 6;
   // clock rate and strap hold time in bus clock cycles
   localparam int SLO_CLK_MHZ = 50;
   localparam int SLO_STRAP_HOLD_CYC = 10;
   // reset values
   localparam logic SLO_STRAP_RST = 1'h0;
   localparam logic [3:0] SLO_CNT_RST = 4'h0;
   // sampling sequence states
   typedef enum logic [1:0] {
      SLO_IN_RESET = 2'b00,
      SLO_SAMPLING = 2'b01,
      SLO_LOCKED = 2'b10
   } slo_state_t;
endpackage

// file: pkg/slo_lane_if.sv
`timescale 1ns/1ns
// lane order and width control handed to the lane mapper
interface slo_lane_if;
   logic reverse;
   logic narrow;
   logic [1:0] sel [0:3];
   modport ctrl (output reverse, output narrow, input sel);
   modport map (input reverse, input narrow, output sel);
endinterface

// file: logic/slo_lane_map.sv
`timescale 1ns/1ns
// picks the physical lane for each logical lane of one port
module slo_lane_map
   import slo_pkg::*;
(
   slo_lane_if.map lif
);
   // reversal only applies in four-lane operation
   genvar g;
   generate
      for (g = 0; g < SLO_LANES; g++) begin : g_lane
         assign lif.sel[g] = (lif.reverse && !lif.narrow) ? 2'(3 - g) : 2'(g);
      end
   endgenerate
endmodule // slo_lane_map

// file: tb/slo_board.sv
`timescale 1ns/1ns
// board side: reset source and strap tie-offs
module slo_board (
   input wire logic clk_in,
   input wire logic hold_rst_in,
   input wire logic rx_level_in,
   input wire logic tx_level_in,
   output logic hard_rst_n_out,
   output logic rx_strap_out,
   output logic tx_strap_out
);
   // the device has no supply detector, so the board makes the reset
   always_ff @(posedge clk_in) hard_rst_n_out <= !hold_rst_in;
   // tie-offs stay put through the hold time after release
   assign rx_strap_out = rx_level_in;
   assign tx_strap_out = tx_level_in;
endmodule // slo_board

// file: tb/test_serial_lane_order_strap.sv
`timescale 1ns/1ns
module test_serial_lane_order_strap;
   import slo_pkg::*;
   logic ref_clk_in = 0, srst_in = 1, hold = 1, rx_l = 0, tx_l = 0, irq_req_in = 0;
   logic [7:0] narrow_mode_in = 8'h00;
   logic hr_n, rx_s, tx_s, rx_rev, tx_rev, locked, int_n, int_oe;
   logic [63:0] rx_sel, tx_sel;
   logic [7:0] wide;
   int bad_count = 0, checks_done = 0, cycles = 0;
   // rows: rx strap, tx strap, narrow ports
   logic [9:0] rows [4] = '{10'h000, 10'h300, 10'h241, 10'h1ff};
   always #10 ref_clk_in = ~ref_clk_in;
   slo_board board (.clk_in(ref_clk_in), .hold_rst_in(hold), .rx_level_in(rx_l),
      .tx_level_in(tx_l), .hard_rst_n_out(hr_n), .rx_strap_out(rx_s), .tx_strap_out(tx_s));
   slo_strap_top DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .hard_rst_n_in(hr_n),
      .rx_lane_reverse_strap_in(rx_s), .tx_lane_reverse_strap_in(tx_s),
      .narrow_mode_in(narrow_mode_in), .irq_req_in(irq_req_in), .rx_lane_sel_out(rx_sel),
      .tx_lane_sel_out(tx_sel), .rx_reverse_out(rx_rev), .tx_reverse_out(tx_rev),
      .straps_locked_out(locked), .wide_only_out(wide), .int_n_out(int_n),
      .int_n_oe_out(int_oe));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
      end
   endtask
   // only the two reversible ports (0 and 6) reverse, and rx not while narrow
   function automatic logic [63:0] exp_sel(logic rev, logic [7:0] nar);
      for (int p = 0; p < 8; p++) begin
         exp_sel[p*8+:8] = (rev && !nar[p] && (p == SLO_REV_PORT_A || p == SLO_REV_PORT_B))
            ? 8'h1b : 8'he4;
      end
   endfunction
   // reset pulse from the board, then wait for the straps to lock
   task automatic boot(logic rx, logic tx);
      int i;
      hold = 1;
      rx_l = rx;
      tx_l = tx;
      repeat (3) @(negedge ref_clk_in);
      hold = 0;
      repeat (10) @(negedge ref_clk_in);
      check("early_lock", locked, 1'h0);
      for (i = 0; i < 40 && locked !== 1'b1; i++) @(negedge ref_clk_in);
      check("locked", locked, 1'h1);
   endtask
   // hang guard, well above the roughly 180 cycles needed
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk_in);
      srst_in = 0;
      foreach (rows[r]) begin
         boot(rows[r][9], rows[r][8]);
         narrow_mode_in = rows[r][7:0];
         repeat (2) @(negedge ref_clk_in);
         check("rx_sel", rx_sel, exp_sel(rows[r][9], rows[r][7:0]));
         check("tx_sel", tx_sel, exp_sel(rows[r][8], 8'h00));
         check("wide", wide, (rows[r][9] | rows[r][8]) ? 8'h41 : 8'h00);
      end
      // straps reworked after lock must not reach the captures
      rx_l = 1;
      tx_l = 0;
      repeat (20) @(negedge ref_clk_in);
      check("rx_rev", rx_rev, 1'h0);
      check("tx_rev", tx_rev, 1'h1);
      // hard reset in mid-run clears the captures
      hold = 1;
      repeat (4) @(negedge ref_clk_in);
      check("hr_locked", locked, 1'h0);
      check("hr_tx_rev", tx_rev, 1'h0);
      check("hr_tx_sel", tx_sel, 64'h0);
      boot(1, 1);
      srst_in = 1;
      repeat (2) @(negedge ref_clk_in);
      check("srst_locked", locked, 1'h0);
      check("srst_rx_rev", rx_rev, 1'h0);
      check("srst_rx_sel", rx_sel, 64'h0);
      srst_in = 0;
      boot(0, 0);
      irq_req_in = 1;
      repeat (2) @(negedge ref_clk_in);
      check("irq_on", {int_oe, int_n}, 2'h2);
      irq_req_in = 0;
      repeat (2) @(negedge ref_clk_in);
      check("irq_off", {int_oe, int_n}, 2'h0);
      // strap moves one cycle after its hold time: the held level must stick
      hold = 1;
      rx_l = 1;
      repeat (3) @(negedge ref_clk_in);
      hold = 0;
      repeat (11) @(negedge ref_clk_in);
      rx_l = 0;
      repeat (10) @(negedge ref_clk_in);
      check("late_move", rx_rev, 1'h1);
      print_verdict();
   end
endmodule // test_serial_lane_order_strap
